//--- dbgtr_params.svh
// Constants for the debug trigger and trace block
`ifndef DBGTR_PARAMS_SVH
`define DBGTR_PARAMS_SVH

`define DBGTR_OFS_CMPA_HI 4'h0
`define DBGTR_OFS_CMPA_LO 4'h1
`define DBGTR_OFS_CMPB_HI 4'h2
`define DBGTR_OFS_CMPB_LO 4'h3
`define DBGTR_OFS_FIFO_HI 4'h4
`define DBGTR_OFS_FIFO_LO 4'h5
`define DBGTR_OFS_CTRL 4'h6
`define DBGTR_OFS_TRIG 4'h7
`define DBGTR_OFS_STAT 4'h8

`define DBGTR_C_ON 7
`define DBGTR_C_ARM 6
`define DBGTR_C_TAG 5
`define DBGTR_C_BRK 4
`define DBGTR_C_RWA 3
`define DBGTR_C_DIR_QUALIFY_EN_A 2
`define DBGTR_C_RWB 1
`define DBGTR_C_DIR_QUALIFY_EN_B 0
`define DBGTR_T_OPSEL 7
`define DBGTR_T_BEGIN 6

`define DBGTR_CTRL_RST 8'h00
`define DBGTR_TRIG_RST 8'h00
`define DBGTR_CMP_RST 16'h0000

`define DBGTR_COUNT_FULL 4'h8
`define DBGTR_COF_BLANK 2'h2
`define DBGTR_TQ_DEPTH 3'h4

`endif

//--- dbgtr_pkg.sv
// Types shared by the debug trigger and trace block
package dbgtr_pkg;

	typedef enum logic [3:0] {
		tm_a_only, tm_a_or_b, tm_a_then_b, tm_event_b, tm_a_then_event_b,
		tm_a_and_b_data, tm_a_and_not_b_data, tm_inside, tm_outside
	} dbgtr_mode_e;

	typedef enum logic [2:0] {
		cof_none, cof_branch_cond, cof_branch_uncond, cof_indirect,
		cof_interrupt, cof_rti, cof_rts
	} dbgtr_cof_e;

	typedef enum logic [1:0] {st_off, st_wait, st_store} dbgtr_run_e;

	typedef struct packed {
		logic cyc;
		logic [15:0] addr;
		logic rd;
		logic [7:0] rdata;
		logic [7:0] wdata;
		logic fetch;
		logic exec;
		logic flush;
		logic bdc_access;
		dbgtr_cof_e cof;
		logic cof_taken;
		logic [15:0] cof_src;
		logic [15:0] cof_dst;
	} dbgtr_cpu_s;

	typedef struct packed {
		logic tag_req;
		logic force_req;
		logic use_swi;
	} dbgtr_brk_s;

	typedef struct packed {
		logic [15:0] cmp_a;
		logic [15:0] cmp_b;
		logic [7:0] ctrl;
		logic [7:0] trig;
		logic af;
		logic bf;
		dbgtr_run_e run;
		logic active;
		logic [3:0] count;
		logic [7:0][15:0] fifo;
		logic [1:0] blank;
		logic [3:0] tqa;
		logic [2:0] tqa_n;
		logic [3:0] tqb;
		logic [2:0] tqb_n;
		logic [15:0] last_op;
		logic [7:0] rdata;
		dbgtr_brk_s brk;
	} dbgtr_state_s;

endpackage

//--- dbgtr_trace.sv
// Debug comparators, trigger modes, trace FIFO and break requests
//
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/100ps
`include "dbgtr_params.svh"

module dbgtr_trace
	import dbgtr_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// CPU side
	input wire dbgtr_cpu_s cpu,
	input wire logic background_permit,
	output dbgtr_brk_s brk,
	output logic run_active_flag
);

	dbgtr_state_s s_reg;
	dbgtr_state_s s_next;

	// Opcode tracker: pops on execute, pushes on fetch, drops on queue flush
	function automatic logic [7:0] tq_step(input logic [3:0] q, input logic [2:0] n,
		input logic push, input logic pb, input logic pop, input logic fl);
		logic [3:0] nq;
		logic [2:0] nn;
		logic hit;
		nq = q;
		nn = n;
		hit = 1'b0;
		if (fl)
		begin
			nq = 4'h0;
			nn = 3'h0;
		end
		else
		begin
			if (pop && nn != 3'h0)
			begin
				hit = nq[0];
				nq = {1'b0, nq[3:1]};
				nn = nn - 3'h1;
			end
			if (push && nn < `DBGTR_TQ_DEPTH)
			begin
				nq[nn[1:0]] = pb;
				nn = nn + 3'h1;
			end
		end
		return {hit, nq, nn};
	endfunction

	// Shift toward the port and enter a new word at the back
	function automatic logic [7:0][15:0] fifo_shift(input logic [7:0][15:0] f,
		input logic [15:0] v);
		logic [7:0][15:0] r;
		r = {v, f[7:1]};
		return r;
	endfunction

	function automatic logic [3:0] count_inc(input logic [3:0] c);
		return (c == `DBGTR_COUNT_FULL) ? c : c + 4'h1;
	endfunction

	always_comb
	begin
		logic cyc;
		logic ma_raw;
		logic mb_raw;
		logic qa;
		logic qb;
		logic dmatch;
		logic [7:0] dsel;
		logic [7:0] tra;
		logic [7:0] trb;
		logic trig;
		logic brk_src;
		logic is_event;
		logic is_full;
		logic begin_eff;
		logic cof_ok;
		logic [15:0] cof_val;
		logic push;
		logic [15:0] push_val;
		logic arm_start;
		logic arm_stop;
		logic armed;
		logic stop_run;
		dbgtr_mode_e mode;
		// Defaults first: every temporary has a value on every path
		ma_raw = 1'b0;
		mb_raw = 1'b0;
		qa = 1'b0;
		qb = 1'b0;
		dmatch = 1'b0;
		dsel = 8'h00;
		tra = 8'h00;
		trb = 8'h00;
		trig = 1'b0;
		brk_src = 1'b0;
		cof_ok = 1'b0;
		cof_val = 16'h0000;
		arm_start = 1'b0;
		arm_stop = 1'b0;
		s_next = s_reg;
		cyc = cpu.cyc && !cpu.bdc_access;
		mode = dbgtr_mode_e'(s_reg.trig[3:0]);
		is_event = (mode == tm_event_b) || (mode == tm_a_then_event_b);
		is_full = (mode == tm_a_and_b_data) || (mode == tm_a_and_not_b_data);
		begin_eff = is_event || s_reg.trig[`DBGTR_T_BEGIN];
		armed = s_reg.run != st_off;
		push = 1'b0;
		push_val = 16'h0000;
		stop_run = 1'b0;

		// Comparator matches with optional direction qualify
		ma_raw = cyc && cpu.addr == s_reg.cmp_a && (!s_reg.ctrl[`DBGTR_C_DIR_QUALIFY_EN_A]
			|| cpu.rd == s_reg.ctrl[`DBGTR_C_RWA]);
		mb_raw = cyc && cpu.addr == s_reg.cmp_b && (!s_reg.ctrl[`DBGTR_C_DIR_QUALIFY_EN_B]
			|| cpu.rd == s_reg.ctrl[`DBGTR_C_RWB]);
		// Write bus only when A is qualified to writes
		dsel = (s_reg.ctrl[`DBGTR_C_DIR_QUALIFY_EN_A] && !s_reg.ctrl[`DBGTR_C_RWA]) ? cpu.wdata
			: cpu.rdata;
		dmatch = dsel == s_reg.cmp_b[7:0];

		// Independent trackers so several tagged fetches can be in flight
		tra = tq_step(s_reg.tqa, s_reg.tqa_n, cpu.fetch, cpu.addr == s_reg.cmp_a,
			cpu.exec, cpu.flush);
		trb = tq_step(s_reg.tqb, s_reg.tqb_n, cpu.fetch, cpu.addr == s_reg.cmp_b,
			cpu.exec, cpu.flush);
		s_next.tqa = tra[6:3];
		s_next.tqa_n = tra[2:0];
		s_next.tqb = trb[6:3];
		s_next.tqb_n = trb[2:0];
		qa = s_reg.trig[`DBGTR_T_OPSEL] ? tra[7] : ma_raw;
		qb = s_reg.trig[`DBGTR_T_OPSEL] ? trb[7] : mb_raw;

		case (mode)
			tm_a_only: trig = qa;
			tm_a_or_b: trig = qa || qb;
			tm_a_then_b: trig = s_reg.af && qb;
			tm_event_b: trig = qb;
			tm_a_then_event_b: trig = s_reg.af && qb;
			tm_a_and_b_data: trig = qa && dmatch;
			tm_a_and_not_b_data: trig = qa && !dmatch;
			tm_inside: trig = cyc && cpu.addr >= s_reg.cmp_a
				&& cpu.addr <= s_reg.cmp_b;
			tm_outside: trig = cyc && (cpu.addr < s_reg.cmp_a
				|| cpu.addr > s_reg.cmp_b);
			default: trig = 1'b0;
		endcase

		// Change-of-flow selection
		cof_ok = 1'b0;
		cof_val = cpu.cof_dst;
		if (cpu.cof == cof_branch_cond && cpu.cof_taken)
		begin
			cof_ok = 1'b1;
			cof_val = cpu.cof_src;
		end
		else if (cpu.cof == cof_indirect || cpu.cof == cof_interrupt
			|| cpu.cof == cof_rti || cpu.cof == cof_rts)
		begin
			cof_ok = 1'b1;
		end

		// Arm needs the enable bit too; any other control write is a stop
		arm_start = reg_wr && reg_addr == `DBGTR_OFS_CTRL && reg_wdata[`DBGTR_C_ARM]
			&& reg_wdata[`DBGTR_C_ON];
		arm_stop = reg_wr && reg_addr == `DBGTR_OFS_CTRL && !arm_start;

		// Run sequencing
		case (s_reg.run)
			st_wait:
			begin
				if (is_event)
				begin
					if (trig)
					begin
						push = 1'b1;
						push_val = {8'h00, dsel};
						stop_run = count_inc(s_reg.count) == `DBGTR_COUNT_FULL;
					end
				end
				else if (!begin_eff)
				begin
					// Circular store; a flow change in the trigger cycle is the last one
					if (cof_ok)
					begin
						push = 1'b1;
						push_val = cof_val;
					end
					stop_run = trig;
				end
				else if (trig)
				begin
					// Trigger cycle and two following bus cycles are blind
					s_next.run = st_store;
					s_next.blank = `DBGTR_COF_BLANK;
				end
			end
			st_store:
			begin
				if (cyc && s_reg.blank != 2'h0)
				begin
					s_next.blank = s_reg.blank - 2'h1;
				end
				if (cof_ok && s_reg.blank == 2'h0)
				begin
					push = 1'b1;
					push_val = cof_val;
					stop_run = count_inc(s_reg.count) == `DBGTR_COUNT_FULL;
				end
			end
			default:
			begin
				s_next.run = st_off;
			end
		endcase

		// Flags: a set in the arm cycle still wins
		s_next.af = (arm_start ? 1'b0 : s_reg.af) || (armed && qa);
		s_next.bf = (arm_start ? 1'b0 : s_reg.bf) || (armed && qb);

		// Low port read shifts; unarmed it feeds the profiler
		if (reg_rd && reg_addr == `DBGTR_OFS_FIFO_LO)
		begin
			s_next.fifo = fifo_shift(s_reg.fifo, s_reg.ctrl[`DBGTR_C_ARM] ? 16'h0000
				: s_reg.last_op);
		end
		if (push)
		begin
			s_next.fifo = fifo_shift(s_next.fifo, push_val);
			s_next.count = count_inc(s_reg.count);
		end
		// Manual stop short of full shifts once more, so the host
		// skips one read fewer than the empty slots would suggest
		if (arm_stop && armed && s_reg.count != `DBGTR_COUNT_FULL)
		begin
			s_next.fifo = fifo_shift(s_next.fifo, 16'h0000);
		end
		if (cpu.fetch)
		begin
			s_next.last_op = cpu.addr;
		end
		if (stop_run)
		begin
			s_next.run = st_off;
			s_next.ctrl[`DBGTR_C_ARM] = 1'b0;
		end

		// Break requests
		brk_src = (is_full && s_reg.ctrl[`DBGTR_C_TAG]) ? qa : trig;
		brk_src = brk_src && armed && s_reg.ctrl[`DBGTR_C_BRK];
		s_next.brk.tag_req = brk_src && s_reg.ctrl[`DBGTR_C_TAG];
		s_next.brk.force_req = brk_src && !s_reg.ctrl[`DBGTR_C_TAG];
		// Permit is sampled every cycle, so the fallback follows the host
		s_next.brk.use_swi = !background_permit;

		// Register writes
		if (reg_wr)
		begin
			if (reg_addr == `DBGTR_OFS_CMPA_HI)
			begin
				s_next.cmp_a[15:8] = reg_wdata;
			end
			else if (reg_addr == `DBGTR_OFS_CMPA_LO)
			begin
				s_next.cmp_a[7:0] = reg_wdata;
			end
			else if (reg_addr == `DBGTR_OFS_CMPB_HI)
			begin
				s_next.cmp_b[15:8] = reg_wdata;
			end
			else if (reg_addr == `DBGTR_OFS_CMPB_LO)
			begin
				s_next.cmp_b[7:0] = reg_wdata;
			end
			else if (reg_addr == `DBGTR_OFS_CTRL)
			begin
				s_next.ctrl = reg_wdata;
				s_next.ctrl[`DBGTR_C_ARM] = arm_start;
			end
			else if (reg_addr == `DBGTR_OFS_TRIG)
			begin
				s_next.trig = reg_wdata;
			end
		end
		if (arm_start)
		begin
			s_next.run = st_wait;
			s_next.count = 4'h0;
			s_next.blank = 2'h0;
		end
		else if (arm_stop)
		begin
			s_next.run = st_off;
		end
		// Run flag gets its own flop so the pin is not a decode of the state
		s_next.active = s_next.run != st_off;

		// Read data stands only in the cycle after the strobe
		s_next.rdata = 8'h00;
		if (reg_rd)
		begin
			if (reg_addr == `DBGTR_OFS_CMPA_HI)
			begin
				s_next.rdata = s_reg.cmp_a[15:8];
			end
			else if (reg_addr == `DBGTR_OFS_CMPA_LO)
			begin
				s_next.rdata = s_reg.cmp_a[7:0];
			end
			else if (reg_addr == `DBGTR_OFS_CMPB_HI)
			begin
				s_next.rdata = s_reg.cmp_b[15:8];
			end
			else if (reg_addr == `DBGTR_OFS_CMPB_LO)
			begin
				s_next.rdata = s_reg.cmp_b[7:0];
			end
			else if (reg_addr == `DBGTR_OFS_FIFO_HI)
			begin
				s_next.rdata = s_reg.fifo[0][15:8];
			end
			else if (reg_addr == `DBGTR_OFS_FIFO_LO)
			begin
				s_next.rdata = s_reg.fifo[0][7:0];
			end
			else if (reg_addr == `DBGTR_OFS_CTRL)
			begin
				s_next.rdata = s_reg.ctrl;
			end
			else if (reg_addr == `DBGTR_OFS_TRIG)
			begin
				s_next.rdata = s_reg.trig;
			end
			else if (reg_addr == `DBGTR_OFS_STAT)
			begin
				s_next.rdata = {s_reg.af, s_reg.bf, armed, 1'b0, s_reg.count};
			end
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			s_reg <= '0;
			s_reg.ctrl <= `DBGTR_CTRL_RST;
			s_reg.trig <= `DBGTR_TRIG_RST;
			s_reg.cmp_a <= `DBGTR_CMP_RST;
			s_reg.cmp_b <= `DBGTR_CMP_RST;
			s_reg.run <= st_off;
		end
		else
		begin
			s_reg <= s_next;
		end
	end

	assign reg_rdata = s_reg.rdata;
	assign brk = s_reg.brk;
	assign run_active_flag = s_reg.active;

endmodule

//--- dbgtr_trace_sva.sv
// Port assertions for the debug trigger and trace block
`timescale 1ns/100ps
module dbgtr_trace_sva
	import dbgtr_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// CPU side
	input wire dbgtr_cpu_s cpu,
	input wire logic background_permit,
	input wire dbgtr_brk_s brk,
	input wire logic run_active_flag
);
	logic [7:0] ctrl_reg;
	wire arm_wr = reg_wr && reg_addr == 4'h6 && reg_wdata[7] && reg_wdata[6];
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	// Written copy only, since the arm bit self-clears
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			ctrl_reg <= 8'h00;
		else if (reg_wr && reg_addr == 4'h6)
			ctrl_reg <= reg_wdata;
	end
	a_arm_sets_run: assert property (arm_wr |=> run_active_flag)
		else $error("arm write left run flag low");
	a_disarm_stops: assert property (
		reg_wr && reg_addr == 4'h6 && !arm_wr |=> !run_active_flag)
		else $error("run flag survived disarm");
	a_arm_clr_count: assert property (
		arm_wr ##1 (reg_rd && reg_addr == 4'h8) |=> reg_rdata[3:0] == 4'h0)
		else $error("count not cleared by arm");
	a_count_limit: assert property (
		reg_rd && reg_addr == 4'h8 |=> reg_rdata[3:0] <= 4'h8)
		else $error("count above eight");
	a_rdata_stands: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data outside its cycle");
	a_break_allowed: assert property (
		brk.tag_req || brk.force_req |-> $past(ctrl_reg[4]) && $past(run_active_flag))
		else $error("break while not allowed");
	a_break_kind: assert property (
		brk.tag_req || brk.force_req |->
		brk.tag_req == $past(ctrl_reg[5]) && !(brk.tag_req && brk.force_req))
		else $error("wrong break type");
	a_swi_fallback: assert property (
		1'b1 |=> brk.use_swi == !$past(background_permit))
		else $error("software interrupt select wrong");
endmodule

//--- dbgtr_cpu_model.sv
// CPU bus model for the debug block's CPU side
`timescale 1ns/100ps
module dbgtr_cpu_model
	import dbgtr_pkg::*;
(
	// Clock
	input wire logic mclk,
	// Toward the block
	output dbgtr_cpu_s cpu,
	output logic background_permit
);
	initial
	begin
		cpu = '0;
		background_permit = 1'b0;
	end
	// One bus cycle per call; back to back calls give consecutive cycles
	task automatic step(input dbgtr_cpu_s c);
		@(posedge mclk);
		cpu <= c;
	endtask
	// Released bus shows inverted values so a stale address never matches
	task automatic idle();
		dbgtr_cpu_s c;
		@(posedge mclk);
		c = '0;
		c.addr = ~cpu.addr;
		c.rdata = ~cpu.rdata;
		cpu <= c;
	endtask
	task automatic permit(input logic p);
		@(posedge mclk);
		background_permit <= p;
	endtask
endmodule

//--- dbgtr_trace_bench.sv
// Self-checking bench for the debug trigger and trace block
`timescale 1ns/100ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_count++; \
	$display("unexpected at %0t: got %h want %h", $time, a, e); end end
module dbgtr_trace_bench
	import dbgtr_pkg::*;
;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	dbgtr_cpu_s cpu;
	logic background_permit;
	dbgtr_brk_s brk;
	logic run_active_flag;
	int err_count = 0;
	int checks = 0;
	int cycles = 0;
	logic [15:0] exp_q[$];
	logic [15:0] w;
	logic [7:0] d, h;
	dbgtr_cpu_s c;
	// Mode, first address, second address, data, tag and expect bits
	logic [47:0] tbl [12] = '{48'h080001234001, 48'h080002056000, 48'h180002056001,
		48'h212342056001, 48'h280002056000, 48'h580001234561, 48'h580001234570,
		48'h580001234573, 48'h680001234571, 48'h780001800001, 48'h780003000000,
		48'h880000100001};
	dbgtr_trace u_dbgtr_trace (.mclk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .cpu, .background_permit, .brk, .run_active_flag);
	dbgtr_cpu_model u_dbgtr_cpu_model (.mclk, .cpu, .background_permit);
	initial
	begin
		forever #2 mclk = ~mclk;
	end
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			err_count++;
			print_verdict();
		end
	end
	// Called just after an edge, so requests may follow with no gap
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		// A write lowered in this step lets its edge pass first
		if (reg_wr)
			@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		// Data stand until the next edge; take them where settled
		@(negedge mclk);
		v = reg_rdata;
		@(posedge mclk);
	endtask
	function automatic dbgtr_cpu_s mk(input logic [15:0] a, input logic [7:0] v);
		dbgtr_cpu_s r;
		r = '0;
		r.cyc = 1'b1;
		r.rd = 1'b1;
		r.addr = a;
		r.rdata = v;
		return r;
	endfunction
	// Host word read: high byte, then the low byte that shifts
	task automatic drain(input int n);
		logic [7:0] hb;
		logic [7:0] lb;
		logic [15:0] ew;
		repeat (n)
		begin
			rd(4'h4, hb);
			rd(4'h5, lb);
			ew = exp_q.pop_front();
			`CHK({hb, lb}, ew)
		end
	endtask
	// Trigger cycle first, then random flow changes until n are expected
	task automatic trace(input int n);
		for (int i = 0; i < 60 && exp_q.size() < n; i++)
		begin
			c = mk(i < 1 ? 16'h1234 : 16'h8000, 8'h00);
			c.cof = dbgtr_cof_e'(3'(1 + $urandom % 6));
			c.cof_taken = 1'($urandom % 2);
			c.cof_src = 16'($urandom);
			c.cof_dst = 16'($urandom);
			u_dbgtr_cpu_model.step(c);
			if (i > 2 && (c.cof == cof_branch_cond ? c.cof_taken : c.cof > cof_branch_uncond))
				exp_q.push_back(c.cof == cof_branch_cond ? c.cof_src : c.cof_dst);
		end
		u_dbgtr_cpu_model.idle();
	endtask
	initial
	begin
		void'($urandom(70));
		repeat (8) @(posedge mclk);
		reset_n <= 1'b1;
		rd(4'h8, d);
		`CHK(d, 8'h00)
		rd(4'h9, d);
		`CHK(d, 8'h00)
		$display("done reset");
		wr(4'h0, 8'h12);
		wr(4'h1, 8'h34);
		wr(4'h2, 8'h20);
		wr(4'h3, 8'h56);
		wr(4'h7, 8'h40);
		wr(4'h6, 8'hc0);
		rd(4'h8, d);
		`CHK(d & 8'h2f, 8'h20)
		trace(8);
		repeat (3) @(posedge mclk);
		`CHK(run_active_flag, 1'b0)
		rd(4'h8, d);
		`CHK(d & 8'h2f, 8'h08)
		repeat (8)
		begin
			rd(4'h4, h);
			rd(4'h5, d);
			w = exp_q.pop_front();
			`CHK({h, d}, w)
		end
		$display("done begin trace");
		exp_q.delete();
		wr(4'h6, 8'hc0);
		trace(3);
		wr(4'h6, 8'h80);
		c = mk(16'h8000, 8'h00);
		c.cof = cof_rts;
		repeat (3) u_dbgtr_cpu_model.step(c);
		u_dbgtr_cpu_model.idle();
		rd(4'h8, d);
		`CHK(d & 8'h2f, 8'h03)
		repeat (4) rd(4'h5, d);
		drain(3);
		$display("done manual stop");
		exp_q.delete();
		for (int i = 0; i < 16; i++)
		begin
			c = mk(16'($urandom), 8'h00);
			c.fetch = 1'b1;
			u_dbgtr_cpu_model.step(c);
			u_dbgtr_cpu_model.idle();
			rd(4'h4, h);
			rd(4'h5, d);
			exp_q.push_back(c.addr);
			if (i > 7)
			begin
				w = exp_q.pop_front();
				`CHK({h, d}, w)
			end
		end
		$display("done profiling");
		exp_q.delete();
		wr(4'h7, 8'h03);
		wr(4'h6, 8'hc0);
		for (int i = 0; i < 8; i++)
		begin
			d = 8'($urandom);
			u_dbgtr_cpu_model.step(mk(16'h2056, d));
			exp_q.push_back({8'h00, d});
		end
		u_dbgtr_cpu_model.idle();
		rd(4'h8, d);
		`CHK(d & 8'h2f, 8'h08)
		drain(8);
		$display("done event capture");
		exp_q.delete();
		wr(4'h7, 8'h00);
		wr(4'h6, 8'hc0);
		for (int i = 0; i < 10; i++)
		begin
			c = mk(i < 9 ? 16'h8000 : 16'h1234, 8'h00);
			c.cof = cof_rts;
			c.cof_dst = 16'($urandom);
			u_dbgtr_cpu_model.step(c);
			exp_q.push_back(c.cof_dst);
		end
		u_dbgtr_cpu_model.idle();
		rd(4'h8, d);
		`CHK(d & 8'h2f, 8'h08)
		repeat (2) void'(exp_q.pop_front());
		drain(8);
		$display("done end trace");
		for (int i = 0; i < 12; i++)
		begin
			u_dbgtr_cpu_model.permit(i[0]);
			wr(4'h7, {4'h4, tbl[i][47:44]});
			wr(4'h6, {2'b11, tbl[i][1], 5'h10});
			u_dbgtr_cpu_model.step(mk(tbl[i][43:28], 8'h00));
			u_dbgtr_cpu_model.step(mk(tbl[i][27:12], tbl[i][11:4]));
			u_dbgtr_cpu_model.idle();
			@(negedge mclk);
			`CHK(brk, {tbl[i][1] & tbl[i][0], ~tbl[i][1] & tbl[i][0], ~i[0]})
		end
		$display("done breaks");
		@(posedge mclk);
		wr(4'h7, 8'h40);
		wr(4'h6, 8'hd4);
		u_dbgtr_cpu_model.step(mk(16'h1234, 8'h00));
		u_dbgtr_cpu_model.idle();
		@(negedge mclk);
		`CHK({brk.tag_req, brk.force_req}, 2'b00)
		c = mk(16'h1234, 8'h00);
		c.rd = 1'b0;
		u_dbgtr_cpu_model.step(c);
		u_dbgtr_cpu_model.idle();
		@(negedge mclk);
		`CHK({brk.tag_req, brk.force_req}, 2'b01)
		$display("done direction qualify");
		@(posedge mclk);
		wr(4'h7, 8'h80);
		wr(4'h6, 8'hd0);
		c = mk(16'h1234, 8'h00);
		c.fetch = 1'b1;
		u_dbgtr_cpu_model.step(c);
		c = mk(16'h8000, 8'h00);
		c.flush = 1'b1;
		u_dbgtr_cpu_model.step(c);
		c.flush = 1'b0;
		c.exec = 1'b1;
		u_dbgtr_cpu_model.step(c);
		u_dbgtr_cpu_model.idle();
		@(negedge mclk);
		`CHK({brk.tag_req, brk.force_req}, 2'b00)
		c = mk(16'h1234, 8'h00);
		c.fetch = 1'b1;
		u_dbgtr_cpu_model.step(c);
		c.addr = 16'h8000;
		u_dbgtr_cpu_model.step(c);
		c.fetch = 1'b0;
		c.exec = 1'b1;
		u_dbgtr_cpu_model.step(c);
		u_dbgtr_cpu_model.idle();
		@(negedge mclk);
		`CHK({brk.tag_req, brk.force_req}, 2'b01)
		$display("done opcode qualify");
		print_verdict();
	end
endmodule
bind dbgtr_trace dbgtr_trace_sva u_dbgtr_trace_sva (.mclk, .reset_n, .reg_addr, .reg_wdata,
	.reg_wr, .reg_rd, .reg_rdata, .cpu, .background_permit, .brk, .run_active_flag);
